// ===== hdl/upf_defs.svh
// timing constants for the parallel fifo port host controller
`ifndef UPF_DEFS_SVH
`define UPF_DEFS_SVH

// ---------------------------------------------------------------
// clock and conversion
// ---------------------------------------------------------------
`define UPF_CLK_NS 8
`define UPF_CEIL_CYC(ns) (((ns) + `UPF_CLK_NS - 1) / `UPF_CLK_NS)

// ---------------------------------------------------------------
// pin timing in ns
// ---------------------------------------------------------------
`define UPF_RD_PULSE_NS 50
`define UPF_RD_PRECHG_NS 50
`define UPF_RX_INACT_NS 80
`define UPF_RD_GAP_NS (`UPF_RD_PRECHG_NS + `UPF_RX_INACT_NS)
`define UPF_WR_PULSE_NS 50
`define UPF_WR_PRECHG_NS 50

// ---------------------------------------------------------------
// cycle counts derived from the ns figures
// ---------------------------------------------------------------
`define UPF_RD_PULSE_CYC `UPF_CEIL_CYC(`UPF_RD_PULSE_NS)
`define UPF_RD_GAP_CYC `UPF_CEIL_CYC(`UPF_RD_GAP_NS)
`define UPF_WR_PULSE_CYC `UPF_CEIL_CYC(`UPF_WR_PULSE_NS)
`define UPF_WR_GAP_CYC `UPF_CEIL_CYC(`UPF_WR_PRECHG_NS)

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define UPF_DATA_W 8
`define UPF_CNT_W 5
`define UPF_FIFO_DEPTH 32
`define UPF_CNT_ZERO 5'h00
`define UPF_CNT_MAX 5'h1f
`define UPF_BYTE_ZERO 8'h00

`endif

// ===== hdl/upf_pkg.sv
// types shared by the parallel fifo port host controller
package upf_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WR_PULSE,
      ST_WR_RECOV,
      ST_RD_PULSE,
      ST_RD_RECOV
   } upf_state_e;
endpackage : upf_pkg

// ===== hdl/upf_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module upf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic core_clk, // clock
   input wire logic rst_n, // async reset, active low
   input wire logic [WIDTH-1:0] inData, // write data
   input wire logic inValid, // write request
   output logic inReady, // space available
   output logic [WIDTH-1:0] outData, // head data
   output logic outValid, // data available
   input wire logic outReady // pop request
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   assign inReady = (count_ff != (AW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData = mem_ff[rdPtr_ff];

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_word
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n)
               mem_ff[gi] <= '0;
            else if (push && wrPtr_ff == AW'(gi))
               mem_ff[gi] <= inData;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // pointers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push)
            wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
         if (pop)
            rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
         if (push && !pop)
            count_ff <= count_ff + 1'b1;
         else if (pop && !push)
            count_ff <= count_ff - 1'b1;
      end
   end
endmodule // upf_fifo

// ===== hdl/upf_host_ctrl.sv
// host controller driving the byte-wide parallel fifo port
// What this block does
// - write only while tx_not_ready_n low
// - read only while rx flag low and rxValid low, alternating with pending writes
// - read strobe at least 50 ns, gap at least 50+80 ns
// - write strobe high at least 50 ns
// - write strobes at least 50 ns apart
`timescale 1ns/1ps
`include "upf_defs.svh"
module upf_host_ctrl
   import upf_pkg::*;
#(
   parameter int DATA_W = `UPF_DATA_W,
   parameter int FIFO_DEPTH = `UPF_FIFO_DEPTH,
   parameter int RD_PULSE_CYC = `UPF_RD_PULSE_CYC,
   parameter int RD_GAP_CYC = `UPF_RD_GAP_CYC,
   parameter int WR_PULSE_CYC = `UPF_WR_PULSE_CYC,
   parameter int WR_GAP_CYC = `UPF_WR_GAP_CYC
) (
   input wire logic core_clk, // clock, 125 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic [DATA_W-1:0] txData, // byte to send
   input wire logic txValid, // byte to send valid
   output logic txReady, // fifo can take byte
   output logic [DATA_W-1:0] rxData, // received byte
   output logic rxValid, // received byte valid
   input wire logic rxReady, // user takes byte
   input wire logic [DATA_W-1:0] busIn, // data pins in
   output logic [DATA_W-1:0] busOut, // data pins out
   output logic busOe_n, // data drive, low drives
   output logic rdPin_n, // read strobe, active low
   output logic wrPin, // write strobe, falls to latch
   input wire logic tx_not_ready_n, // high: no write
   input wire logic rx_data_avail_n // low: byte waiting
);
   localparam int CW = `UPF_CNT_W;

   upf_state_e state_ff, nxt_state;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic lastRead_ff;
   logic [DATA_W-1:0] busOut_ff;
   logic busOe_n_ff, rdPin_n_ff, wrPin_ff;
   logic [DATA_W-1:0] rxData_ff;
   logic rxValid_ff;
   logic fifoValid;
   logic [DATA_W-1:0] fifoData;

   // ---------------------------------------------------------------
   // transmit buffer
   // ---------------------------------------------------------------
   wire idle = (state_ff == ST_IDLE);
   wire canWrite = fifoValid && !tx_not_ready_n;
   wire canRead = !rx_data_avail_n && !rxValid_ff;
   wire pickRead = canRead && (!canWrite || !lastRead_ff);
   wire startWr = idle && !pickRead && canWrite;
   wire startRd = idle && pickRead;
   wire cntDone = (cnt_ff == `UPF_CNT_ZERO);
   wire rdCapture = (state_ff == ST_RD_PULSE) && cntDone;

   upf_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_txFifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .inData(txData),
      .inValid(txValid),
      .inReady(txReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(startWr)
   );

   // ---------------------------------------------------------------
   // strobe sequencer
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cntDone ? cnt_ff : cnt_ff - 1'b1;
      case (state_ff)
         ST_IDLE: begin
            if (startRd) begin
               nxt_state = ST_RD_PULSE;
               nxt_cnt = CW'(RD_PULSE_CYC - 1);
            end else if (startWr) begin
               nxt_state = ST_WR_PULSE;
               nxt_cnt = CW'(WR_PULSE_CYC - 1);
            end
         end
         ST_WR_PULSE: begin
            if (cntDone) begin
               nxt_state = ST_WR_RECOV;
               nxt_cnt = CW'(WR_GAP_CYC - 1);
            end
         end
         ST_WR_RECOV: begin
            if (cntDone)
               nxt_state = ST_IDLE;
         end
         ST_RD_PULSE: begin
            if (cntDone) begin
               nxt_state = ST_RD_RECOV;
               nxt_cnt = CW'(RD_GAP_CYC - 1);
            end
         end
         ST_RD_RECOV: begin
            if (cntDone)
               nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_cnt = `UPF_CNT_ZERO;
         end
      endcase
   end

   // drive bus through the pulse and one hold cycle after the fall
   wire nxtWr = (nxt_state == ST_WR_PULSE);
   wire nxtDrive = nxtWr || (state_ff == ST_WR_PULSE);
   wire nxtRd = (nxt_state == ST_RD_PULSE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         cnt_ff <= `UPF_CNT_ZERO;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPin_ff <= 1'b0;
         rdPin_n_ff <= 1'b1;
         busOe_n_ff <= 1'b1;
      end else begin
         wrPin_ff <= nxtWr;
         rdPin_n_ff <= !nxtRd;
         busOe_n_ff <= !nxtDrive;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busOut_ff <= `UPF_BYTE_ZERO;
         lastRead_ff <= 1'b0;
      end else begin
         if (startWr)
            busOut_ff <= fifoData;
         if (idle && (startRd || startWr))
            lastRead_ff <= startRd;
      end
   end

   // ---------------------------------------------------------------
   // receive holding register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxData_ff <= `UPF_BYTE_ZERO;
         rxValid_ff <= 1'b0;
      end else begin
         if (rdCapture)
            rxData_ff <= busIn;
         if (rdCapture)
            rxValid_ff <= 1'b1;
         else if (rxReady)
            rxValid_ff <= 1'b0;
      end
   end

   assign busOut = busOut_ff;
   assign busOe_n = busOe_n_ff;
   assign rdPin_n = rdPin_n_ff;
   assign wrPin = wrPin_ff;
   assign rxData = rxData_ff;
   assign rxValid = rxValid_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [CW-1:0] rdHighCnt_ff;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         rdHighCnt_ff <= `UPF_CNT_MAX;
      else if (!rdPin_n_ff)
         rdHighCnt_ff <= `UPF_CNT_ZERO;
      else if (rdHighCnt_ff != `UPF_CNT_MAX)
         rdHighCnt_ff <= rdHighCnt_ff + 1'b1;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_wr_when_ready: assert property (
      $rose(wrPin) |-> !$past(tx_not_ready_n))
      else $error("write strobe while tx flag high");
   a_wr_pulse_width: assert property (
      $rose(wrPin) |-> wrPin [*7])
      else $error("write strobe too short");
   a_wr_gap_min: assert property (
      $fell(wrPin) |-> !wrPin [*8])
      else $error("write strobes too close");
   a_wr_data_hold: assert property (
      $fell(wrPin) |-> !busOe_n && $stable(busOut))
      else $error("bus released at write fall");
   a_rd_pulse_width: assert property (
      $fell(rdPin_n) |-> !rdPin_n [*7] ##1 rdPin_n)
      else $error("read strobe width wrong");
   a_rd_gap_min: assert property (
      $fell(rdPin_n) |-> $past(rdHighCnt_ff) >= CW'(RD_GAP_CYC))
      else $error("read strobes too close");
   a_rd_when_avail: assert property (
      $fell(rdPin_n) |-> !$past(rx_data_avail_n))
      else $error("read strobe while rx flag high");
   a_bus_no_fight: assert property (
      !rdPin_n |-> busOe_n && !wrPin)
      else $error("host drives bus during read");
   a_rx_hold: assert property (
      rxValid && !rxReady |=> rxValid && $stable(rxData))
      else $error("received byte dropped");

   c_write: cover property ($fell(wrPin));
   c_read: cover property ($rose(rdPin_n) ##1 rxValid);
   c_tx_blocked: cover property (fifoValid && tx_not_ready_n && idle);
   c_back_to_back: cover property ($fell(rdPin_n) ##[1:40] $rose(wrPin));
endmodule // upf_host_ctrl

// ===== testbench/upf_dev_model.sv
// behavioural model of the byte-wide parallel fifo port device
`timescale 1ns/1ps
module upf_dev_model #(
   parameter int RX_DEPTH = 256,
   parameter int TX_DEPTH = 128,
   parameter int FLAG_HOLD = 10
) (
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic [7:0] busOut, // host data out
   input wire logic busOe_n, // host drive, low drives
   input wire logic rdPin_n, // read strobe, active low
   input wire logic wrPin, // write strobe
   input wire logic hostDrain, // usb side takes tx bytes
   output logic [7:0] busWire, // resolved data lines
   output logic tx_not_ready_n, // high: no write
   output logic rx_data_avail_n // low: byte waiting
);
   // ---------------------------------------------------------------
   // buffers, pin checks and flags
   // ---------------------------------------------------------------
   logic [7:0] rxQ[$];
   logic [7:0] txQ[$];
   logic [7:0] sentQ[$];
   logic [7:0] rxHead;
   logic [7:0] floatPat;
   logic rdPrev, wrPrev;
   int txHold, rxHold, rdLow, rdHigh, wrHigh, wrLow;
   int violCnt = 0;
   // released lines toggle so stale data never looks valid
   assign busWire = !busOe_n ? busOut : (!rdPin_n ? rxHead : floatPat);
   task automatic host_send(input logic [7:0] b, output bit taken);
      taken = rxQ.size() < RX_DEPTH;
      if (taken) rxQ.push_back(b);
   endtask
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         txQ.delete();
         sentQ.delete();
         txHold = FLAG_HOLD;
         rxHold = 0;
         rdHigh = 99;
         wrLow = 99;
         rdPrev <= 1'b1;
         wrPrev <= 1'b0;
         floatPat <= 8'h5a;
         tx_not_ready_n <= 1'b1;
         rx_data_avail_n <= 1'b1;
      end else begin
         if (txHold > 0) txHold--;
         if (rxHold > 0) rxHold--;
         if (!busOe_n && !rdPin_n) violCnt++;
         if (!rdPin_n && rdPrev && (rx_data_avail_n || rdHigh < 17))
            violCnt++;
         if (rdPin_n && !rdPrev) begin
            if (rdLow < 7) violCnt++;
            void'(rxQ.pop_front());
            rxHold = FLAG_HOLD;
         end
         if (wrPin && !wrPrev && (tx_not_ready_n || wrLow < 7))
            violCnt++;
         if (!wrPin && wrPrev) begin
            if (wrHigh < 7) violCnt++;
            if (txQ.size() < TX_DEPTH) txQ.push_back(busWire);
            txHold = FLAG_HOLD;
         end
         // no rate setting: bytes leave as fast as the usb side takes them
         if (hostDrain && txQ.size() > 0)
            sentQ.push_back(txQ.pop_front());
         rdLow = rdPin_n ? 0 : rdLow + 1;
         rdHigh = rdPin_n ? rdHigh + 1 : 0;
         wrHigh = wrPin ? wrHigh + 1 : 0;
         wrLow = wrPin ? 0 : wrLow + 1;
         rdPrev <= rdPin_n;
         wrPrev <= wrPin;
         floatPat <= ~floatPat;
         rxHead <= rxQ.size() > 0 ? rxQ[0] : 8'h00;
         tx_not_ready_n <= txQ.size() >= TX_DEPTH || txHold > 0;
         rx_data_avail_n <= rxQ.size() == 0 || rxHold > 0;
      end
   end
endmodule // upf_dev_model

// ===== testbench/testbench.sv
// self-checking testbench for the parallel fifo port host controller
`timescale 1ns/1ps
module testbench;
   // ---------------------------------------------------------------
   // signals, instances and helpers
   // ---------------------------------------------------------------
   logic core_clk, rst_n, txValid, txReady, rxValid, rxReady, hostDrain;
   logic busOe_n, rdPin_n, wrPin, tx_not_ready_n, rx_data_avail_n;
   logic [7:0] txData, rxData, busWire, busOut;
   int error_cnt = 0;
   int n_tests = 0;
   upf_host_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .txData(txData),
      .txValid(txValid), .txReady(txReady), .rxData(rxData),
      .rxValid(rxValid), .rxReady(rxReady), .busIn(busWire),
      .busOut(busOut), .busOe_n(busOe_n), .rdPin_n(rdPin_n), .wrPin(wrPin),
      .tx_not_ready_n(tx_not_ready_n), .rx_data_avail_n(rx_data_avail_n));
   upf_dev_model dev (.core_clk(core_clk), .rst_n(rst_n), .busOut(busOut),
      .busOe_n(busOe_n), .rdPin_n(rdPin_n), .wrPin(wrPin),
      .hostDrain(hostDrain), .busWire(busWire),
      .tx_not_ready_n(tx_not_ready_n), .rx_data_avail_n(rx_data_avail_n));
   function automatic bit bad(input bit c);
      n_tests++;
      return c;
   endfunction
   task automatic fail(input string m);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      @(negedge core_clk);
      if (bad(wrPin !== 1'b0 || rdPin_n !== 1'b1))
         fail("strobes after reset");
      if (bad(busOe_n !== 1'b1 || busOut !== 8'h00))
         fail("bus after reset");
      if (bad(rxValid !== 1'b0 || txReady !== 1'b1))
         fail("stream after reset");
   endtask
   task automatic test_tx_fill;
      int taken;
      int k;
      taken = 0;
      @(posedge core_clk);
      txData <= 8'h00;
      txValid <= 1'b1;
      repeat (3500) begin
         @(negedge core_clk);
         if (txReady === 1'b1) taken++;
         @(posedge core_clk);
         txData <= taken[7:0];
      end
      txValid <= 1'b0;
      if (bad(taken != 160)) fail("bytes taken with device full");
      if (bad(dev.txQ.size() != 128)) fail("device buffer fill");
      hostDrain <= 1'b1;
      for (k = 0; k < 5000 && dev.sentQ.size() < 160; k++) @(negedge core_clk);
      if (bad(dev.sentQ.size() != 160)) fail("bytes sent to usb");
      for (k = 0; k < dev.sentQ.size(); k++)
         if (bad(dev.sentQ[k] !== k[7:0])) fail("written byte order");
      if (bad(dev.violCnt != 0)) fail("write strobe timing");
   endtask
   task automatic test_rx_stall;
      int acc;
      int got;
      int k;
      bit ok;
      acc = 0;
      got = 0;
      for (k = 0; k < 258; k++) begin
         dev.host_send(k[7:0], ok);
         if (ok) acc++;
      end
      if (bad(acc != 256)) fail("host bytes accepted");
      for (k = 0; k < 200 && rxValid !== 1'b1; k++) @(negedge core_clk);
      acc = 0;
      repeat (60) begin
         @(negedge core_clk);
         if (rdPin_n === 1'b0) acc++;
      end
      if (bad(acc != 0 || dev.rxQ.size() != 255))
         fail("read while stalled");
      @(posedge core_clk);
      rxReady <= 1'b1;
      for (k = 0; k < 9000 && got < 256; k++) begin
         @(negedge core_clk);
         if (rxValid === 1'b1) begin
            if (bad(rxData !== got[7:0])) fail("received byte order");
            got++;
         end
      end
      if (bad(got != 256)) fail("received byte count");
      repeat (40) @(negedge core_clk);
      if (bad(rx_data_avail_n !== 1'b1 || rdPin_n !== 1'b1))
         fail("idle at end");
      if (bad(dev.violCnt != 0)) fail("read strobe timing");
   endtask
   task automatic test_mixed;
      int k;
      int got;
      int nRd;
      int nWr;
      bit ok;
      bit rdPrevL;
      bit wrPrevL;
      got = 0;
      nRd = 0;
      nWr = 0;
      rdPrevL = 1'b1;
      wrPrevL = 1'b0;
      for (k = 0; k < 4; k++)
         dev.host_send(8'h40 + k[7:0], ok);
      for (k = 0; k < 800 && (got < 4 || dev.sentQ.size() < 164); k++) begin
         @(posedge core_clk);
         txValid <= (k < 4);
         txData <= 8'ha0 + k[7:0];
         @(negedge core_clk);
         if (rxValid === 1'b1) begin
            if (bad(rxData !== 8'h40 + got[7:0]))
               fail("mixed read byte");
            got++;
         end
         if (rdPin_n === 1'b0 && rdPrevL) begin
            nRd++;
            if (nRd == 2)
               if (bad(nWr == 0))
                  fail("two reads with write pending");
         end
         if (wrPin === 1'b1 && !wrPrevL) begin
            nWr++;
            if (nWr == 2)
               if (bad(nRd < 2))
                  fail("two writes with read pending");
         end
         rdPrevL = rdPin_n;
         wrPrevL = wrPin;
      end
      if (bad(got != 4 || dev.sentQ.size() != 164))
         fail("mixed transfer count");
      for (k = 0; k < 4; k++)
         if (bad(dev.sentQ[160 + k] !== 8'ha0 + k[7:0]))
            fail("mixed write byte");
      if (bad(dev.violCnt != 0)) fail("mixed strobe timing");
   endtask
   // ---------------------------------------------------------------
   // clock, reset, sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      rst_n = 1'b0;
      txData = 8'h00;
      txValid = 1'b0;
      rxReady = 1'b0;
      hostDrain = 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      test_reset();
      test_tx_fill();
      test_rx_stall();
      test_mixed();
      summarize();
   end
   initial begin
      repeat (30000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end
endmodule // testbench
